// *** core/sdmd_pkg.sv ***
package sdmd_pkg;

  localparam logic [15:0] ENTRY_CMD   = 16'hA35C;
  localparam logic [15:0] ENTRY_ACK   = 16'h5CA3;
  localparam logic [15:0] FAULT_RSP   = 16'h83FF;
  localparam logic [15:0] INVALID_RSP = 16'h8000;
  localparam logic [15:0] ZERO_RSP    = 16'h0000;

  localparam logic [4:0] OP_PTR_WR = 5'h09;
  localparam logic [4:0] OP_PTR_RD = 5'h08;
  localparam logic [4:0] OP_DAT_WR = 5'h0B;
  localparam logic [4:0] OP_DAT_RD = 5'h0A;
  localparam logic [4:0] OP_ACC_RD = 5'h0C;

  localparam logic [4:0] HEAD_PTR = 5'h16;
  localparam logic [4:0] HEAD_DAT = 5'h14;
  localparam logic [4:0] HEAD_ACC = 5'h13;
  localparam logic [1:0] TAIL_PTR = 2'h1;
  localparam logic [1:0] TAIL_DAT = 2'h2;

  localparam int          RD_PAR_BIT    = 10;
  localparam logic [7:0]  CFG_TWO_ADDR  = 8'h05;
  localparam int          WIDTH_SEL_BIT = 0;
  localparam logic [7:0]  WIDE_LO_ADDR  = 8'h40;
  localparam logic [7:0]  WIDE_HI_ADDR  = 8'h41;
  localparam logic [7:0]  REG_RST_VAL   = 8'h00;
  localparam int          REG_COUNT     = 256;
  localparam int          SYNC_DEPTH    = 3;
  localparam logic [4:0]  LAST_BIT      = 5'h0F;
  localparam logic [4:0]  WORD_BITS     = 5'h10;

  typedef struct packed {
    logic [4:0] op;
    logic       b10;
    logic       b9;
    logic       b8;
    logic [7:0] low;
  } sdmd_cmd_s;

  typedef struct packed {
    logic       stb;
    logic [7:0] addr;
    logic [7:0] data;
  } sdmd_wr_s;

  typedef enum logic [2:0] {
    ST_WAIT   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_LOCKED = 3'b100
  } sdmd_state_e;

  // Sets the bit at pos so that the whole word has odd parity
  function automatic logic [15:0] odd_fix(input logic [15:0] w,
                                          input int pos);
    logic [15:0] r;
    r = w;
    r[pos] = 1'b0;
    r[pos] = ~(^r);
    return r;
  endfunction

endpackage

// *** core/sdmd_top.sv ***
`timescale 1ns/1ps
module sdmd_top (
  // System clock and reset
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               ce,
  // SPI link
  input  wire logic               spi_sclk,
  input  wire logic               spi_cs_b,
  input  wire logic               spi_mosi,
  output logic                    spi_miso,
  // Device data
  input  wire logic [9:0]         accel_sample,
  input  wire logic [15:0]        wide_value,
  // Status and register write port
  output logic                    dpm_active,
  output logic                    dpm_locked,
  output sdmd_pkg::sdmd_wr_s      reg_wr
);
  import sdmd_pkg::*;

  logic              link_rst_b;
  logic [4:0]        rise_cnt_reg;
  logic [4:0]        fall_cnt_reg;
  logic [15:0]       rx_sh_reg;
  logic [15:0]       rx_word_reg;
  logic              rx_tgl_reg;
  logic [2:0]        cs_sync_reg;
  logic [2:0]        tgl_sync_reg;
  logic              cs_seen_reg;
  logic              tgl_seen_reg;
  logic              got_reg;
  logic              cs_rise;
  logic              tgl_edge;
  logic              decode_go;
  sdmd_state_e       state_reg;
  sdmd_state_e       state_next;
  logic [15:0]       tx_word_reg;
  logic [15:0]       tx_next;
  logic              skip_reg;
  logic              skip_next;
  logic [7:0]        ptr_reg;
  logic [7:0]        ptr_next;
  logic [7:0]        hold_reg;
  logic              freeze;
  sdmd_wr_s          wr_reg;
  sdmd_wr_s          wr_next;
  logic [7:0]        regs_mem [0:REG_COUNT-1];
  sdmd_cmd_s         cmd;
  logic              is_wr;
  logic              is_rd;
  logic              par_ok;
  logic              form_ok;
  logic              width_sel;
  logic [9:0]        acc_val;
  logic [7:0]        rd_byte;

  // Link logic restarts with every frame
  assign link_rst_b = rst_b & ~spi_cs_b;

  always_ff @(posedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      rise_cnt_reg <= 5'h00;
      rx_sh_reg    <= 16'h0000;
    end else begin
      if (rise_cnt_reg != WORD_BITS) begin
        rise_cnt_reg <= rise_cnt_reg + 5'h01;
      end
      rx_sh_reg <= {rx_sh_reg[14:0], spi_mosi};
    end
  end

  // Full word held past the frame, announced by a toggle
  always_ff @(posedge spi_sclk or negedge rst_b) begin
    if (!rst_b) begin
      rx_word_reg <= 16'h0000;
      rx_tgl_reg  <= 1'b0;
    end else if (rise_cnt_reg == LAST_BIT) begin
      rx_word_reg <= {rx_sh_reg[14:0], spi_mosi};
      rx_tgl_reg  <= ~rx_tgl_reg;
    end
  end

  // MSB first, next bit after falling edge
  always_ff @(negedge spi_sclk or negedge link_rst_b) begin
    if (!link_rst_b) begin
      fall_cnt_reg <= 5'h00;
    end else if (fall_cnt_reg != WORD_BITS) begin
      fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end
  end

  // Reply word is stable while chip select is low
  assign spi_miso = fall_cnt_reg[4] ? 1'b0
                  : tx_word_reg[LAST_BIT[3:0] - fall_cnt_reg[3:0]];

  // Three-stage synchronisers for chip select and word toggle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_sync_reg  <= 3'h7;
      tgl_sync_reg <= 3'h0;
      cs_seen_reg  <= 1'b1;
      tgl_seen_reg <= 1'b0;
    end else if (ce) begin
      cs_sync_reg  <= {cs_sync_reg[1:0], spi_cs_b};
      tgl_sync_reg <= {tgl_sync_reg[1:0], rx_tgl_reg};
      if (cs_sync_reg[1] == cs_sync_reg[2]) begin
        cs_seen_reg <= cs_sync_reg[2];
      end
      if (tgl_sync_reg[1] == tgl_sync_reg[2]) begin
        tgl_seen_reg <= tgl_sync_reg[2];
      end
    end
  end

  assign cs_rise  = (cs_sync_reg[1] == cs_sync_reg[2]) & cs_sync_reg[2]
                  & ~cs_seen_reg;
  assign tgl_edge = (tgl_sync_reg[1] == tgl_sync_reg[2])
                  & (tgl_sync_reg[2] != tgl_seen_reg);
  assign decode_go = ce & cs_rise & (got_reg | tgl_edge);
  // Decode consumes the word, even one seen in the same cycle,
  // so a later short frame cannot replay it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      got_reg <= 1'b0;
    end else if (ce) begin
      got_reg <= (tgl_edge | got_reg) & ~cs_rise;
    end
  end
  assign cmd = rx_word_reg;
  assign is_wr = (cmd.op == OP_PTR_WR) | (cmd.op == OP_DAT_WR);
  assign is_rd = (cmd.op == OP_PTR_RD) | (cmd.op == OP_DAT_RD)
               | (cmd.op == OP_ACC_RD);
  assign par_ok = is_wr ? (^rx_word_reg) : (^rx_word_reg[15:RD_PAR_BIT]);
  always_comb begin
    case (cmd.op)
      OP_PTR_WR: form_ok = cmd.b10;
      OP_DAT_WR: form_ok = ~cmd.b10;
      OP_PTR_RD: form_ok = ~cmd.b9;
      OP_DAT_RD: form_ok = ~cmd.b9;
      OP_ACC_RD: form_ok = ~cmd.b9 & ~cmd.b8 & (cmd.low == 8'h00);
      default:   form_ok = 1'b0;
    endcase
  end
  // 8-bit sample when width select is set
  assign width_sel = regs_mem[CFG_TWO_ADDR][WIDTH_SEL_BIT];
  assign acc_val   = width_sel ? {2'b00, accel_sample[7:0]} : accel_sample;
  // high byte comes from the frozen copy
  always_comb begin
    if (ptr_reg == WIDE_LO_ADDR) begin
      rd_byte = wide_value[7:0];
    end else if (ptr_reg == WIDE_HI_ADDR) begin
      rd_byte = hold_reg;
    end else begin
      rd_byte = regs_mem[ptr_reg];
    end
  end

  always_comb begin
    state_next = state_reg;
    tx_next    = tx_word_reg;
    skip_next  = skip_reg;
    ptr_next   = ptr_reg;
    freeze     = 1'b0;
    wr_next    = '0;
    if (decode_go) begin
      case (state_reg)
        ST_WAIT: begin
          // only the first command may enter
          if (rx_word_reg == ENTRY_CMD) begin
            state_next = ST_ACTIVE;
            tx_next    = ENTRY_ACK;
          end else begin
            // lock out on a wrong first word
            state_next = ST_LOCKED;
            tx_next    = ZERO_RSP;
          end
        end
        ST_ACTIVE: begin
          if (skip_reg) begin
            // ignore the command after a fault
            skip_next = 1'b0;
            tx_next   = FAULT_RSP;
          end else if ((is_wr | is_rd) & ~par_ok) begin
            skip_next = 1'b1;
            tx_next   = FAULT_RSP;
          end else if (!form_ok) begin
            tx_next = INVALID_RSP;
          end else begin
            case (cmd.op)
              OP_PTR_WR: begin
                ptr_next = cmd.low;
                tx_next  = odd_fix({HEAD_PTR, 1'b0, TAIL_PTR, 8'h00},
                                   RD_PAR_BIT);
              end
              OP_PTR_RD: begin
                tx_next = odd_fix({HEAD_PTR, 1'b0, TAIL_PTR, ptr_reg},
                                  RD_PAR_BIT);
              end
              OP_DAT_WR: begin
                wr_next = '{stb: 1'b1, addr: ptr_reg, data: cmd.low};
                tx_next = odd_fix({HEAD_DAT, 1'b0, TAIL_DAT, ptr_reg},
                                  RD_PAR_BIT);
              end
              OP_DAT_RD: begin
                freeze  = (ptr_reg == WIDE_LO_ADDR);
                tx_next = odd_fix({HEAD_DAT, 1'b0, TAIL_DAT, rd_byte},
                                  RD_PAR_BIT);
              end
              OP_ACC_RD: begin
                tx_next = odd_fix({HEAD_ACC, 1'b0, acc_val}, RD_PAR_BIT);
              end
              default: tx_next = INVALID_RSP;
            endcase
          end
        end
        ST_LOCKED: tx_next = ZERO_RSP;
        default: begin
          state_next = ST_LOCKED;
          tx_next    = ZERO_RSP;
        end
      endcase
    end
  end

  // active and locked states are held until reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_WAIT;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_word_reg <= ZERO_RSP;
      skip_reg    <= 1'b0;
    end else if (ce) begin
      tx_word_reg <= tx_next;
      skip_reg    <= skip_next;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ptr_reg  <= 8'h00;
      hold_reg <= 8'h00;
    end else if (ce) begin
      ptr_reg <= ptr_next;
      if (freeze) begin
        hold_reg <= wide_value[15:8];
      end
    end
  end

  // write lands on the release decode cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        regs_mem[i] <= REG_RST_VAL;
      end
    end else if (ce & wr_next.stb) begin
      regs_mem[wr_next.addr] <= wr_next.data;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_reg <= '0;
    end else if (ce) begin
      wr_reg <= wr_next;
    end
  end

  assign dpm_active = state_reg[1];
  assign dpm_locked = state_reg[2];
  assign reg_wr     = wr_reg;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_entry_accept: assert property (
    decode_go && state_reg == ST_WAIT && rx_word_reg == ENTRY_CMD
    |=> state_reg == ST_ACTIVE && tx_word_reg == ENTRY_ACK)
    else $error("entry word not accepted");
  a_entry_lockout: assert property (
    decode_go && state_reg == ST_WAIT && rx_word_reg != ENTRY_CMD
    |=> state_reg == ST_LOCKED && tx_word_reg == ZERO_RSP)
    else $error("wrong first word did not lock out");
  a_locked_stays: assert property (
    state_reg == ST_LOCKED |=> state_reg == ST_LOCKED
    && tx_word_reg == ZERO_RSP)
    else $error("lockout left or gave nonzero reply");
  a_active_stays: assert property (
    state_reg == ST_ACTIVE |=> state_reg == ST_ACTIVE)
    else $error("active mode left without reset");
  a_reply_parity: assert property (
    state_reg == ST_ACTIVE && tx_word_reg != ENTRY_ACK |-> ^tx_word_reg)
    else $error("reply without odd parity");
  a_fault_reply: assert property (
    decode_go && state_reg == ST_ACTIVE && !skip_reg && is_rd && !par_ok
    |=> skip_reg && tx_word_reg == FAULT_RSP)
    else $error("parity fault not answered");
  a_skip_ignores: assert property (
    decode_go && state_reg == ST_ACTIVE && skip_reg
    |=> !skip_reg && $stable(ptr_reg) && !wr_reg.stb)
    else $error("command after fault not ignored");
  a_ptr_load: assert property (
    decode_go && state_reg == ST_ACTIVE && !skip_reg && is_wr && par_ok
    && form_ok && cmd.op == OP_PTR_WR
    |=> ptr_reg == $past(rx_word_reg[7:0]) && tx_word_reg[7:0] == 8'h00)
    else $error("pointer write failed");
  a_wide_freeze: assert property (
    freeze && ce |=> hold_reg == $past(wide_value[15:8]))
    else $error("high byte not frozen");
  a_acc_width: assert property (
    decode_go && state_reg == ST_ACTIVE && !skip_reg && par_ok && form_ok
    && cmd.op == OP_ACC_RD && width_sel |=> tx_word_reg[9:8] == 2'b00)
    else $error("8-bit sample has upper bits set");
  c_entry: cover property (decode_go && rx_word_reg == ENTRY_CMD
    && state_reg == ST_WAIT);
  c_lockout: cover property (state_reg == ST_WAIT ##1 state_reg == ST_LOCKED);
  c_fault: cover property (skip_reg ##[1:200] !skip_reg);
  c_write: cover property (wr_reg.stb);

endmodule // sdmd_top

// *** test/sdmd_spi_master.sv ***
`timescale 1ns/1ps
module sdmd_spi_master (
  // SPI link
  output logic      spi_sclk,
  output logic      spi_cs_b,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end

  // mode 0, MSB first, caller supplies parity
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    int i;
    rx = 16'h0000;
    #13.7;
    spi_cs_b = 1'b0;
    for (i = 15; i >= 0; i--) begin
      spi_mosi = tx[i];
      #62.5;
      spi_sclk = 1'b1;
      rx[i] = spi_miso;
      #62.5;
      spi_sclk = 1'b0;
    end
    #62.5;
    spi_cs_b = 1'b1;
    // Released data line shows no stale value
    spi_mosi = ~spi_mosi;
    #500;
  endtask
endmodule // sdmd_spi_master

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
  import sdmd_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic [9:0]  accel_sample = 10'h000;
  logic [15:0] wide_value = 16'h0000;
  wire         spi_sclk, spi_cs_b, spi_mosi, spi_miso;
  logic        dpm_active, dpm_locked;
  sdmd_wr_s    reg_wr;
  int          err_count = 0;
  int          compares = 0;
  int          cycles = 0;
  integer      seed;
  logic [15:0] pend, w, hw, wr_seen = 16'h0000, wr_last, n, pz;
  logic [7:0]  a, d;
  logic [9:0]  s;
  int          k;

  always #20 clk = ~clk;

  sdmd_top i_sdmd_top (.clk(clk), .rst_b(rst_b), .ce(ce),
    .spi_sclk(spi_sclk), .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .accel_sample(accel_sample),
    .wide_value(wide_value), .dpm_active(dpm_active),
    .dpm_locked(dpm_locked), .reg_wr(reg_wr));

  sdmd_spi_master i_sdmd_spi_master (.spi_sclk(spi_sclk),
    .spi_cs_b(spi_cs_b), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  always @(posedge clk) begin
    if (reg_wr.stb === 1'b1) begin
      wr_seen <= wr_seen + 16'h0001;
      wr_last <= {reg_wr.addr, reg_wr.data};
    end
  end

  task automatic end_of_test();
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [15:0] rdc(input logic [4:0] op);
    logic [15:0] r;
    r = {op, 11'h000};
    r[10] = ~(^r[15:11]);
    return r;
  endfunction

  function automatic logic [15:0] wrc(input logic [4:0] op,
                                      input logic b, input logic [7:0] v);
    logic [15:0] r;
    r = {op, b, 2'h0, v};
    r[9] = ~(^r);
    return r;
  endfunction

  function automatic logic [15:0] rsp(input logic [4:0] h,
                                      input logic [10:0] t);
    logic [15:0] r;
    r = {h, t};
    r[10] = ~(^r);
    return r;
  endfunction

  // Reply of each command is checked during the following frame
  task automatic issue(input logic [15:0] c, input logic [15:0] e);
    logic [15:0] rx;
    i_sdmd_spi_master.xfer(c, rx);
    chk(rx, pend);
    pend = e;
  endtask

  task automatic rst();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    pend = ZERO_RSP;
  endtask

  initial begin
    seed = 32'h13FE;
    pz = rsp(HEAD_PTR, {1'b0, TAIL_PTR, 8'h00});
    rst();
    w = ENTRY_CMD ^ (16'($random(seed)) | 16'h0001);
    issue(w, ZERO_RSP);
    issue(ENTRY_CMD, ZERO_RSP);
    issue(rdc(OP_PTR_RD), ZERO_RSP);
    chk({15'h0000, dpm_locked}, 16'h0001);
    chk({15'h0000, dpm_active}, 16'h0000);
    rst();
    chk({15'h0000, dpm_locked}, 16'h0000);
    issue(ENTRY_CMD, ENTRY_ACK);
    issue(rdc(OP_PTR_RD), pz);
    chk({15'h0000, dpm_active}, 16'h0001);
    for (k = 0; k < 4; k++) begin
      a = {1'b1, 7'($random(seed))};
      d = 8'($random(seed));
      n = wr_seen;
      issue(wrc(OP_PTR_WR, 1'b1, a), pz);
      issue(wrc(OP_DAT_WR, 1'b0, d),
            rsp(HEAD_DAT, {1'b0, TAIL_DAT, a}));
      issue(rdc(OP_DAT_RD), rsp(HEAD_DAT, {1'b0, TAIL_DAT, d}));
      issue(rdc(OP_PTR_RD), rsp(HEAD_PTR, {1'b0, TAIL_PTR, a}));
      chk(wr_last, {a, d});
      chk(wr_seen - n, 16'h0001);
    end
    s = 10'($random(seed));
    @(posedge clk);
    accel_sample <= s;
    issue(rdc(OP_ACC_RD), rsp(HEAD_ACC, {1'b0, s}));
    issue(wrc(OP_PTR_WR, 1'b1, CFG_TWO_ADDR), pz);
    issue(wrc(OP_DAT_WR, 1'b0, 8'h01 << WIDTH_SEL_BIT),
          rsp(HEAD_DAT, {1'b0, TAIL_DAT, CFG_TWO_ADDR}));
    issue(rdc(OP_ACC_RD), rsp(HEAD_ACC, {3'h0, s[7:0]}));
    issue(wrc(OP_PTR_WR, 1'b1, 8'h33) ^ 16'h0200, FAULT_RSP);
    issue(rdc(OP_PTR_RD), FAULT_RSP);
    issue(rdc(OP_PTR_RD),
          rsp(HEAD_PTR, {1'b0, TAIL_PTR, CFG_TWO_ADDR}));
    issue(rdc(OP_DAT_RD) ^ 16'h0400, FAULT_RSP);
    issue(rdc(OP_DAT_RD), FAULT_RSP);
    hw = 16'($random(seed));
    @(posedge clk);
    wide_value <= hw;
    issue(wrc(OP_PTR_WR, 1'b1, WIDE_LO_ADDR), pz);
    issue(rdc(OP_DAT_RD), rsp(HEAD_DAT, {1'b0, TAIL_DAT, hw[7:0]}));
    issue(wrc(OP_PTR_WR, 1'b1, WIDE_HI_ADDR), pz);
    @(posedge clk);
    wide_value <= ~hw;
    issue(rdc(OP_DAT_RD), rsp(HEAD_DAT, {1'b0, TAIL_DAT, hw[15:8]}));
    issue(rdc(5'h0E), INVALID_RSP);
    issue(rdc(OP_PTR_RD),
          rsp(HEAD_PTR, {1'b0, TAIL_PTR, WIDE_HI_ADDR}));
    n = wr_seen;
    issue(wrc(OP_DAT_WR, 1'b1, 8'h5A), INVALID_RSP);
    issue(ENTRY_CMD, INVALID_RSP);
    i_sdmd_spi_master.xfer(rdc(OP_PTR_RD), w);
    chk(w, pend);
    chk(wr_seen - n, 16'h0000);
    chk({15'h0000, dpm_active}, 16'h0001);
    end_of_test();
  end
endmodule // tb
